/* File: logic/dss_scheduler.sv */
/*
  seasonal (daylight saving) scheduler: eight setting bytes, arming and change decision.
  assumes byte register port in the clock domain and bcd clock counters that follow the steps.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dss_defs.svh"

module dss_scheduler
  import dss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] rtc_hour,
  input wire logic [7:0] rtc_date,
  input wire logic [7:0] rtc_month,
  input wire logic [7:0] rtc_year,
  input wire logic [2:0] rtc_weekday,
  input wire logic flag_clear,
  output logic seasonal_adjusted_flag,
  output logic hour_step_fwd,
  output logic hour_step_back
);

  logic [7:0] start_month_sel;
  logic [7:0] start_weekday_week;
  logic [7:0] start_date_sel;
  logic [7:0] start_hour_sel;
  logic [7:0] end_month_sel;
  logic [7:0] end_weekday_week;
  logic [7:0] end_date_sel;
  logic [7:0] end_hour_sel;
  logic [7:0] next_rdata;
  logic next_flag;
  dss_arm_t fwd_state;
  dss_arm_t rev_state;
  dss_arm_t next_fwd_state;
  dss_arm_t next_rev_state;

  // write strobes
  wire logic wr_fm = reg_we && (reg_addr == `DSS_ADDR_FWD_MONTH);
  wire logic wr_fw = reg_we && (reg_addr == `DSS_ADDR_FWD_WKDY);
  wire logic wr_fd = reg_we && (reg_addr == `DSS_ADDR_FWD_DATE);
  wire logic wr_fh = reg_we && (reg_addr == `DSS_ADDR_FWD_HOUR);
  wire logic wr_rm = reg_we && (reg_addr == `DSS_ADDR_REV_MONTH);
  wire logic wr_rw = reg_we && (reg_addr == `DSS_ADDR_REV_WKDY);
  wire logic wr_rd = reg_we && (reg_addr == `DSS_ADDR_REV_DATE);
  wire logic wr_rh = reg_we && (reg_addr == `DSS_ADDR_REV_HOUR);

  wire logic seasonal_master_enable = start_month_sel[`DSS_ENABLE_BIT];

  // eight setting bytes with unused bits held at zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_month_sel <= `DSS_RST_FWD_MONTH;
      start_weekday_week <= `DSS_RST_FWD_WKDY;
      start_date_sel <= `DSS_RST_FWD_DATE;
      start_hour_sel <= `DSS_RST_FWD_HOUR;
      end_month_sel <= `DSS_RST_REV_MONTH;
      end_weekday_week <= `DSS_RST_REV_WKDY;
      end_date_sel <= `DSS_RST_REV_DATE;
      end_hour_sel <= `DSS_RST_REV_HOUR;
    end else if (ce) begin
      if (wr_fm) begin
        start_month_sel <= reg_wdata & `DSS_MASK_FWD_MONTH;
      end
      if (wr_fw) begin
        start_weekday_week <= reg_wdata & `DSS_MASK_WKDY;
      end
      if (wr_fd) begin
        start_date_sel <= reg_wdata & `DSS_MASK_DATE;
      end
      if (wr_fh) begin
        start_hour_sel <= reg_wdata & `DSS_MASK_HOUR;
      end
      if (wr_rm) begin
        end_month_sel <= reg_wdata & `DSS_MASK_MONTH;
      end
      if (wr_rw) begin
        end_weekday_week <= reg_wdata & `DSS_MASK_WKDY;
      end
      if (wr_rd) begin
        end_date_sel <= reg_wdata & `DSS_MASK_DATE;
      end
      if (wr_rh) begin
        end_hour_sel <= reg_wdata & `DSS_MASK_HOUR;
      end
    end
  end

  // read selection, unmapped offsets read zero
  always_comb begin
    if (reg_addr == `DSS_ADDR_FWD_MONTH) begin
      next_rdata = start_month_sel;
    end else if (reg_addr == `DSS_ADDR_FWD_WKDY) begin
      next_rdata = start_weekday_week;
    end else if (reg_addr == `DSS_ADDR_FWD_DATE) begin
      next_rdata = start_date_sel;
    end else if (reg_addr == `DSS_ADDR_FWD_HOUR) begin
      next_rdata = start_hour_sel;
    end else if (reg_addr == `DSS_ADDR_REV_MONTH) begin
      next_rdata = end_month_sel;
    end else if (reg_addr == `DSS_ADDR_REV_WKDY) begin
      next_rdata = end_weekday_week;
    end else if (reg_addr == `DSS_ADDR_REV_DATE) begin
      next_rdata = end_date_sel;
    end else if (reg_addr == `DSS_ADDR_REV_HOUR) begin
      next_rdata = end_hour_sel;
    end else begin
      next_rdata = `DSS_RST_RDATA;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= `DSS_RST_RDATA;
    end else if (ce && reg_re) begin
      reg_rdata <= next_rdata;
    end
  end

  // week of month and last week of the running calendar
  wire logic [5:0] date_bin = dss_bcd2bin(rtc_date);
  wire logic [5:0] month_bin = dss_bcd2bin(rtc_month);
  wire logic [5:0] year_bin = dss_bcd2bin(rtc_year);
  wire logic leap = (year_bin[1:0] == 2'b00);
  wire logic [4:0] month_days = dss_days(month_bin[3:0], leap);
  wire logic [2:0] week_of_month = (date_bin <= 6'd7) ? 3'h1 :
                                   (date_bin <= 6'd14) ? 3'h2 :
                                   (date_bin <= 6'd21) ? 3'h3 :
                                   (date_bin <= 6'd28) ? 3'h4 : 3'h5;
  wire logic last_week = ({1'b0, date_bin} + 7'h07) > {2'b00, month_days};

  wire logic fwd_day;
  wire logic fwd_at_hour;
  wire logic fwd_early;
  wire logic rev_day;
  wire logic rev_at_hour;
  wire logic rev_early;

  // start side
  dss_change_match u_fwd (
    .month_sel(start_month_sel),
    .weekday_week(start_weekday_week),
    .date_sel(start_date_sel),
    .hour_sel(start_hour_sel),
    .rtc_month(rtc_month),
    .rtc_date(rtc_date),
    .rtc_weekday(rtc_weekday),
    .rtc_hour(rtc_hour),
    .week_of_month(week_of_month),
    .last_week(last_week),
    .day_match(fwd_day),
    .at_hour(fwd_at_hour),
    .hour_early(fwd_early)
  );

  // end side
  dss_change_match u_rev (
    .month_sel(end_month_sel),
    .weekday_week(end_weekday_week),
    .date_sel(end_date_sel),
    .hour_sel(end_hour_sel),
    .rtc_month(rtc_month),
    .rtc_date(rtc_date),
    .rtc_weekday(rtc_weekday),
    .rtc_hour(rtc_hour),
    .week_of_month(week_of_month),
    .last_week(last_week),
    .day_match(rev_day),
    .at_hour(rev_at_hour),
    .hour_early(rev_early)
  );

  // arming needs at least one whole hour of lead, and the right season
  wire logic fwd_arm_ok = seasonal_master_enable && !seasonal_adjusted_flag &&
                          (!fwd_day || fwd_early);
  wire logic rev_arm_ok = seasonal_master_enable && seasonal_adjusted_flag &&
                          (!rev_day || rev_early);
  wire logic fwd_fire = (fwd_state == DSS_ARMED) && seasonal_master_enable &&
                        fwd_day && fwd_at_hour;
  wire logic rev_fire = (rev_state == DSS_ARMED) && seasonal_master_enable &&
                        rev_day && rev_at_hour;

  always_comb begin
    next_fwd_state = fwd_state;
    case (fwd_state)
      DSS_IDLE: begin
        if (fwd_arm_ok) begin
          next_fwd_state = DSS_ARMED;
        end
      end
      DSS_ARMED: begin
        if (!seasonal_master_enable || fwd_fire) begin
          next_fwd_state = DSS_IDLE;
        end
      end
      default: next_fwd_state = DSS_IDLE;
    endcase
  end

  always_comb begin
    next_rev_state = rev_state;
    case (rev_state)
      DSS_IDLE: begin
        if (rev_arm_ok) begin
          next_rev_state = DSS_ARMED;
        end
      end
      DSS_ARMED: begin
        if (!seasonal_master_enable || rev_fire) begin
          next_rev_state = DSS_IDLE;
        end
      end
      default: next_rev_state = DSS_IDLE;
    endcase
  end

  // adjusted flag: disable forces zero, hardware set beats software clear
  always_comb begin
    if (!seasonal_master_enable) begin
      next_flag = 1'b0;
    end else if (fwd_fire) begin
      next_flag = 1'b1;
    end else if (rev_fire) begin
      next_flag = 1'b0;
    end else if (flag_clear) begin
      next_flag = 1'b0;
    end else begin
      next_flag = seasonal_adjusted_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwd_state <= DSS_IDLE;
      rev_state <= DSS_IDLE;
      seasonal_adjusted_flag <= 1'b0;
      hour_step_fwd <= 1'b0;
      hour_step_back <= 1'b0;
    end else if (ce) begin
      fwd_state <= next_fwd_state;
      rev_state <= next_rev_state;
      seasonal_adjusted_flag <= next_flag;
      hour_step_fwd <= fwd_fire;
      hour_step_back <= rev_fire;
    end
  end

  // checks
  a_reset_values: assert property (@(posedge clk)
    !rst_n |=> (start_month_sel == 8'h00 && end_month_sel == 8'h10 && !seasonal_adjusted_flag))
    else $error("setting bytes or flag wrong after reset");

  a_flag_forced_off: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !seasonal_master_enable) |=> !seasonal_adjusted_flag)
    else $error("adjusted flag kept while disabled");

  a_no_step_off: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !seasonal_master_enable) |=> (!hour_step_fwd && !hour_step_back))
    else $error("change fired while disabled");

  a_arm_needs_lead: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && $rose(fwd_state == DSS_ARMED)) |-> $past(fwd_arm_ok))
    else $error("forward armed without an hour of lead");

  a_fwd_step_once: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && fwd_fire) |=> (hour_step_fwd && seasonal_adjusted_flag) ##1 !hour_step_fwd)
    else $error("forward step not single or flag not set");

  a_rev_step_once: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && rev_fire) |=> (hour_step_back && !seasonal_adjusted_flag) ##1 !hour_step_back)
    else $error("reverse step not single or flag not cleared");

  a_date_select: assert property (@(posedge clk) disable iff (!rst_n)
    (fwd_day && !start_weekday_week[`DSS_PRIO_BIT]) |->
      (rtc_date[5:0] == start_date_sel[5:0] && rtc_month[4:0] == start_month_sel[4:0]))
    else $error("forward day matched off the date");

  a_weekday_select: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_day && end_weekday_week[`DSS_PRIO_BIT]) |->
      (rtc_weekday == end_weekday_week[2:0]))
    else $error("reverse day matched off the weekday");

  a_write_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_rm) |=> (end_month_sel == ($past(reg_wdata) & 8'h1F)))
    else $error("reverse month write not masked");

  a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && reg_re && !reg_we && reg_addr == `DSS_ADDR_FWD_HOUR) |=>
      (reg_rdata == start_hour_sel))
    else $error("forward hour reads back wrong");

  a_rev_arm_lead: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && $rose(rev_state == DSS_ARMED)) |-> $past(rev_arm_ok))
    else $error("reverse armed without an hour of lead");

  a_fwd_flag_low: assert property (@(posedge clk) disable iff (!rst_n)
    fwd_fire |-> !seasonal_adjusted_flag)
    else $error("forward change fired in seasonal time");

  a_fwd_weekday: assert property (@(posedge clk) disable iff (!rst_n)
    (fwd_day && start_weekday_week[`DSS_PRIO_BIT]) |->
      (rtc_weekday == start_weekday_week[2:0]))
    else $error("forward day matched off the weekday");

  a_rev_date: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_day && !end_weekday_week[`DSS_PRIO_BIT]) |->
      (rtc_date[5:0] == end_date_sel[5:0]))
    else $error("reverse day matched off the date");

  a_rev_last_week: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_day && end_weekday_week[`DSS_PRIO_BIT] && end_weekday_week[5:3] == 3'h7) |->
      last_week)
    else $error("reverse last week matched early");

  a_rev_week_num: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_day && end_weekday_week[`DSS_PRIO_BIT] && end_weekday_week[5:3] != 3'h7) |->
      (week_of_month == end_weekday_week[5:3]))
    else $error("reverse week of month mismatched");

  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> ($stable(reg_rdata) && $stable(seasonal_adjusted_flag) &&
      $stable(hour_step_fwd) && $stable(hour_step_back)))
    else $error("state moved while clock enable low");

endmodule : dss_scheduler
`default_nettype wire

/* File: logic/dss_defs.svh */
/*
  register offsets, field positions, write masks and reset values of the seasonal control bank.
  assumes inclusion by bare name from design files and the bench.
*/
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

`define DSS_ADDR_FWD_MONTH 8'h20
`define DSS_ADDR_FWD_WKDY 8'h21
`define DSS_ADDR_FWD_DATE 8'h22
`define DSS_ADDR_FWD_HOUR 8'h23
`define DSS_ADDR_REV_MONTH 8'h24
`define DSS_ADDR_REV_WKDY 8'h25
`define DSS_ADDR_REV_DATE 8'h26
`define DSS_ADDR_REV_HOUR 8'h27

`define DSS_MASK_FWD_MONTH 8'h9F
`define DSS_MASK_MONTH 8'h1F
`define DSS_MASK_WKDY 8'h7F
`define DSS_MASK_DATE 8'h3F
`define DSS_MASK_HOUR 8'h3F

`define DSS_RST_FWD_MONTH 8'h00
`define DSS_RST_FWD_WKDY 8'h00
`define DSS_RST_FWD_DATE 8'h00
`define DSS_RST_FWD_HOUR 8'h00
`define DSS_RST_REV_MONTH 8'h10
`define DSS_RST_REV_WKDY 8'h00
`define DSS_RST_REV_DATE 8'h00
`define DSS_RST_REV_HOUR 8'h00
`define DSS_RST_RDATA 8'h00

`define DSS_ENABLE_BIT 7
`define DSS_PRIO_BIT 6
`define DSS_WEEK_MSB 5
`define DSS_WEEK_LSB 3
`define DSS_DOW_MSB 2
`define DSS_LAST_WEEK 3'h7
`define DSS_MIL_BIT 7

`endif

/* File: logic/dss_pkg.sv */
/*
  types and shared calendar arithmetic of the seasonal scheduler.
  assumes bcd coded clock registers as the running clock keeps them.
*/
package dss_pkg;

  typedef enum logic {DSS_IDLE, DSS_ARMED} dss_arm_t;

  function automatic logic [5:0] dss_bcd2bin(input logic [7:0] b);
    logic [7:0] t;
    t = {4'h0, b[7:4]} * 8'h0A + {4'h0, b[3:0]};
    return t[5:0];
  endfunction : dss_bcd2bin

  // hour field to 0..23, mode taken from the clock's flag
  function automatic logic [4:0] dss_hr24(input logic twentyfour_hour_flag, input logic [5:0] h);
    logic [5:0] v;
    v = twentyfour_hour_flag ? dss_bcd2bin({2'b00, h}) : dss_bcd2bin({3'b000, h[4:0]});
    if (!twentyfour_hour_flag) begin
      if (v == 6'h0C) begin
        v = 6'h00;
      end
      if (h[5]) begin
        v = v + 6'h0C;
      end
    end
    return v[4:0];
  endfunction : dss_hr24

  function automatic logic [4:0] dss_days(input logic [3:0] month, input logic leap);
    case (month)
      4'h2: dss_days = leap ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: dss_days = 5'h1E;
      default: dss_days = 5'h1F;
    endcase
  endfunction : dss_days

endpackage : dss_pkg

/* File: logic/dss_change_match.sv */
/*
  compares one change setting (month, day/week or date, hour) with the running calendar.
  assumes week of month and last week flag are worked out by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dss_defs.svh"

module dss_change_match
  import dss_pkg::*;
(
  input wire logic [7:0] month_sel,
  input wire logic [7:0] weekday_week,
  input wire logic [7:0] date_sel,
  input wire logic [7:0] hour_sel,
  input wire logic [7:0] rtc_month,
  input wire logic [7:0] rtc_date,
  input wire logic [2:0] rtc_weekday,
  input wire logic [7:0] rtc_hour,
  input wire logic [2:0] week_of_month,
  input wire logic last_week,
  output logic day_match,
  output logic at_hour,
  output logic hour_early
);
  wire logic [2:0] sel_week = weekday_week[`DSS_WEEK_MSB:`DSS_WEEK_LSB];
  wire logic [2:0] sel_dow = weekday_week[`DSS_DOW_MSB:0];
  wire logic prio = weekday_week[`DSS_PRIO_BIT];
  wire logic week_ok = (sel_week == `DSS_LAST_WEEK) ? last_week : (sel_week == week_of_month);
  wire logic dow_ok = week_ok && (sel_dow == rtc_weekday);
  wire logic date_ok = (date_sel[5:0] == rtc_date[5:0]);
  wire logic month_ok = (month_sel[4:0] == rtc_month[4:0]);
  wire logic twentyfour_hour_flag = rtc_hour[`DSS_MIL_BIT];
  wire logic [5:0] now24 = {1'b0, dss_hr24(twentyfour_hour_flag, rtc_hour[5:0])} + 6'h01;
  wire logic [5:0] tgt24 = {1'b0, dss_hr24(twentyfour_hour_flag, hour_sel[5:0])};

  assign day_match = month_ok && (prio ? dow_ok : date_ok);
  assign at_hour = (hour_sel[5:0] == rtc_hour[5:0]);
  assign hour_early = (now24 < tgt24);

endmodule : dss_change_match
`default_nettype wire

/* File: verif/dss_scheduler_bench.sv */
/*
  self-checking bench of the seasonal scheduler: setting bank, arming and both changes.
  assumes the bench alone drives every port of the scheduler, at falling clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dss_defs.svh"

module dss_scheduler_bench
  import dss_pkg::*;
;
  localparam int LIMIT = 3000;
  logic clk;
  logic rst_n;
  logic ce;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_rdata;
  logic [7:0] rtc_hour;
  logic [7:0] rtc_date;
  logic [7:0] rtc_month;
  logic [7:0] rtc_year;
  logic [2:0] rtc_weekday;
  logic flag_clear;
  logic seasonal_adjusted_flag;
  logic hour_step_fwd;
  logic hour_step_back;
  logic [7:0] n_fwd;
  logic [7:0] n_back;
  logic [7:0] q;
  logic [7:0] wd [8];
  int miscompares;
  int num_checks;
  int cycles;

  dss_scheduler dut_u (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .rtc_hour(rtc_hour),
    .rtc_date(rtc_date), .rtc_month(rtc_month), .rtc_year(rtc_year),
    .rtc_weekday(rtc_weekday), .flag_clear(flag_clear),
    .seasonal_adjusted_flag(seasonal_adjusted_flag), .hour_step_fwd(hour_step_fwd),
    .hour_step_back(hour_step_back)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // step pulses counted per edge, so a pulse standing two cycles counts twice
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (hour_step_fwd === 1'b1) n_fwd <= n_fwd + 8'h01;
    if (hour_step_back === 1'b1) n_back <= n_back + 8'h01;
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  function automatic logic [7:0] exp_rst(input int i);
    return (i == 4) ? 8'h10 : 8'h00;
  endfunction : exp_rst

  function automatic logic [7:0] exp_mask(input int i);
    case (i)
      0: return 8'h9F;
      4: return 8'h1F;
      1, 5: return 8'h7F;
      default: return 8'h3F;
    endcase
  endfunction : exp_mask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic rtc(input logic [7:0] m, input logic [7:0] d, input logic [2:0] w,
                     input logic [7:0] h);
    @(negedge clk);
    rtc_month = m;
    rtc_date = d;
    rtc_weekday = w;
    rtc_hour = h;
  endtask : rtc

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask : settle

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    n_fwd = 8'h00;
    n_back = 8'h00;
  endtask : do_reset

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, miscompares);
  endtask : test_end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    rtc_hour = 8'h80;
    rtc_date = 8'h00;
    rtc_month = 8'h00;
    rtc_year = 8'h23;
    rtc_weekday = 3'h0;
    flag_clear = 1'b0;
    n_fwd = 8'h00;
    n_back = 8'h00;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    void'($urandom(32'h0335_c036));
    do_reset();
    // reset values, masked random writes, ce freeze, unmapped places
    for (int i = 0; i < 8; i++) begin
      rd(8'h20 + i[7:0], q);
      check(q, exp_rst(i));
    end
    check({7'h00, seasonal_adjusted_flag}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wd[i] = 8'($urandom);
      wr(8'h20 + i[7:0], wd[i]);
    end
    wr(8'h28, 8'($urandom));
    for (int i = 0; i < 8; i++) begin
      rd(8'h20 + i[7:0], q);
      check(q, wd[i] & exp_mask(i));
    end
    ce = 1'b0;
    wr(8'h24, ~wd[4]);
    ce = 1'b1;
    rd(8'h24, q);
    check(q, wd[4] & 8'h1F);
    rd(8'h28, q);
    check(q, 8'h00);
    rd(8'h1F, q);
    check(q, 8'h00);
    test_end("registers");
    do_reset();
    // forward change by calendar date, 24 hour clock
    rtc(8'h03, 8'h08, 3'h4, 8'h80);
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h08);
    wr(8'h23, 8'h02);
    wr(8'h20, 8'h83);
    settle();
    check(n_fwd, 8'h00);
    rtc(8'h03, 8'h08, 3'h4, 8'h82);
    settle();
    check(n_fwd, 8'h01);
    check({7'h00, seasonal_adjusted_flag}, 8'h01);
    rtc(8'h03, 8'h08, 3'h4, 8'h83);
    settle();
    check(n_fwd, 8'h01);
    test_end("forward_date");
    // reverse change in the last week, weekday selected, date field ignored
    rtc(8'h10, 8'h29, 3'h0, 8'h80);
    wr(8'h24, 8'h10);
    wr(8'h27, 8'h02);
    wr(8'h25, 8'h78);
    wr(8'h26, 8'h05);
    settle();
    check(n_back, 8'h00);
    rtc(8'h10, 8'h29, 3'h0, 8'h82);
    settle();
    check(n_back, 8'h01);
    check({7'h00, seasonal_adjusted_flag}, 8'h00);
    rtc(8'h10, 8'h29, 3'h0, 8'h81);
    settle();
    check(n_back, 8'h01);
    test_end("reverse_last_week");
    // forward by second week and weekday, 12 hour clock at 2 pm
    rtc(8'h03, 8'h12, 3'h0, 8'h12);
    wr(8'h21, 8'h50);
    wr(8'h22, 8'h01);
    wr(8'h23, 8'h22);
    settle();
    rtc(8'h03, 8'h12, 3'h0, 8'h22);
    settle();
    check(n_fwd, 8'h02);
    check({7'h00, seasonal_adjusted_flag}, 8'h01);
    rtc(8'h03, 8'h12, 3'h0, 8'h23);
    flag_clear = 1'b1;
    settle();
    flag_clear = 1'b0;
    check({7'h00, seasonal_adjusted_flag}, 8'h00);
    test_end("forward_week");
    // master enable off forces the flag low, late enable gives no change
    rtc(8'h03, 8'h12, 3'h0, 8'h80);
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h12);
    wr(8'h23, 8'h02);
    settle();
    rtc(8'h03, 8'h12, 3'h0, 8'h82);
    settle();
    check(n_fwd, 8'h03);
    wr(8'h20, 8'h03);
    settle();
    check({7'h00, seasonal_adjusted_flag}, 8'h00);
    rtc(8'h03, 8'h12, 3'h0, 8'h81);
    wr(8'h20, 8'h83);
    settle();
    rtc(8'h03, 8'h12, 3'h0, 8'h82);
    settle();
    check(n_fwd, 8'h03);
    check({7'h00, seasonal_adjusted_flag}, 8'h00);
    test_end("enable_timing");
    conclude();
  end
endmodule : dss_scheduler_bench

`default_nettype wire
